/* hw/eipc_pkg.sv */
// Constants, types and register map of the external interrupt priority controller
package eipc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CC    = 8'h30;
   localparam logic [7:0] IDX_PRIO0 = 8'h37;
   localparam logic [7:0] IDX_PRIO3 = 8'h3A;
   localparam logic [7:0] IDX_SENS0 = 8'h3B;
   localparam logic [7:0] IDX_SENS1 = 8'h3C;
   localparam logic [7:0] IDX_EN_A  = 8'h3D;
   localparam logic [7:0] IDX_EN_E  = 8'h41;
   localparam logic [7:0] IDX_FL_A  = 8'h42;
   localparam logic [7:0] IDX_FL_E  = 8'h46;
   // Reset values
   localparam logic [7:0] CC_RESET   = 8'hEA;
   localparam logic [7:0] PRIO_RESET = 8'hFF;
   localparam logic [7:0] REG_ZERO   = 8'h00;
   // Field positions, vector and group counts
   localparam int CC_HI_BIT = 5;
   localparam int CC_LO_BIT = 3;
   localparam int NUM_VEC   = 14;
   localparam int NUM_GRP   = 5;
   localparam int EXT_BASE  = 4;
   // Priority codes
   localparam logic [1:0] PRIO_L0 = 2'h2;
   localparam logic [1:0] PRIO_L1 = 2'h1;
   localparam logic [1:0] PRIO_L2 = 2'h0;
   localparam logic [1:0] PRIO_L3 = 2'h3;
   // Pin sensitivity modes
   typedef enum logic [1:0] {
      SENS_FALL_LOW = 2'b00,
      SENS_RISE     = 2'b01,
      SENS_FALL     = 2'b10,
      SENS_BOTH     = 2'b11
   } eipc_sens_e;
   // Events from the CPU core
   typedef struct packed {
      logic       enter;
      logic [3:0] vec;
      logic       nmi;
      logic       ret;
      logic       cc_load;
      logic [7:0] cc_val;
   } eipc_cpu_evt_s;
endpackage

/* hw/eipc_top.sv */
// Interrupt priority, pin sensing and flag logic with a Wishbone register slave
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
module eipc_top (
   input  wire logic                   clock_i,
   input  wire logic                   rst_i,
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [9:0]             adr_i,
   input  wire logic [31:0]            dat_i,
   input  wire logic [3:0]             sel_i,
   output      logic                   ack_o,
   output      logic [31:0]            dat_o,
   input  wire eipc_pkg::eipc_cpu_evt_s cpu_evt_i,
   input  wire logic [13:0]            vec_pend_i,
   input  wire logic [39:0]            pin_i,
   output      logic [7:0]             cc_o,
   output      logic [27:0]            vec_prio_o,
   output      logic [4:0]             grp_irq_o,
   output      logic                   reenter_o
);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   logic [7:0]       cc_q;
   logic [7:0]       cc_d;
   logic [3:0][7:0]  prio_q;
   logic [3:0][7:0]  prio_d;
   logic [7:0]       sens0_q;
   logic [7:0]       sens0_d;
   logic [1:0]       sens1_q;
   logic [1:0]       sens1_d;
   logic [39:0]      en_q;
   logic [39:0]      en_d;
   logic [39:0]      flag_q;
   logic [39:0]      flag_d;
   logic [39:0]      sync1_q;
   logic [39:0]      sync2_q;
   logic [39:0]      prev_q;
   logic             ack_q;
   logic [7:0]       dat_q;
   logic [3:0]       run_vec_q;
   logic             run_q;
   logic             reenter_q;
   logic             reenter_d;
   logic [4:0]       irq_q;

   //------------------------------------------------------------
   // Level of a priority code, 0 lowest
   //------------------------------------------------------------
   function automatic logic [1:0] code_level(input logic [1:0] code);
      logic [1:0] lv;
      lv = 2'h3;
      case (code)
         eipc_pkg::PRIO_L0: lv = 2'h0;
         eipc_pkg::PRIO_L1: lv = 2'h1;
         eipc_pkg::PRIO_L2: lv = 2'h2;
         default:           lv = 2'h3;
      endcase
      return lv;
   endfunction

   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   logic [7:0] idx;
   logic [7:0] poff;
   logic [7:0] eoff;
   logic [7:0] foff;
   logic       req;
   logic       wr;
   logic       hit_cc;
   logic       hit_prio;
   logic       hit_s0;
   logic       hit_s1;
   logic       hit_en;
   logic       hit_fl;
   logic [7:0] wdat;
   logic       at_l3;

   // Register index and hit per register group
   assign idx      = adr_i[9:2];
   assign poff     = idx - eipc_pkg::IDX_PRIO0;
   assign eoff     = idx - eipc_pkg::IDX_EN_A;
   assign foff     = idx - eipc_pkg::IDX_FL_A;
   assign req      = cyc_i & stb_i;
   assign wr       = req & we_i & sel_i[0] & ack_q; // Takes effect on the acked edge
   assign wdat     = dat_i[7:0];
   assign hit_cc   = (idx == eipc_pkg::IDX_CC);
   assign hit_prio = (idx >= eipc_pkg::IDX_PRIO0) && (idx <= eipc_pkg::IDX_PRIO3);
   assign hit_s0   = (idx == eipc_pkg::IDX_SENS0);
   assign hit_s1   = (idx == eipc_pkg::IDX_SENS1);
   assign hit_en   = (idx >= eipc_pkg::IDX_EN_A) && (idx <= eipc_pkg::IDX_EN_E);
   assign hit_fl   = (idx >= eipc_pkg::IDX_FL_A) && (idx <= eipc_pkg::IDX_FL_E);
   assign at_l3    = cc_q[eipc_pkg::CC_HI_BIT] & cc_q[eipc_pkg::CC_LO_BIT];

   //------------------------------------------------------------
   // Read view of the priority registers
   //------------------------------------------------------------
   logic [3:0][7:0] prio_rd;
   logic [31:0]     prio_flat;

   // Upper half of the last register always reads ones
   assign prio_rd[0] = prio_q[0];
   assign prio_rd[1] = prio_q[1];
   assign prio_rd[2] = prio_q[2];
   assign prio_rd[3] = {4'hF, prio_q[3][3:0]};
   assign prio_flat  = prio_rd;
   assign vec_prio_o = prio_flat[27:0];

   //------------------------------------------------------------
   // Read data mux; unmapped indices read zero
   //------------------------------------------------------------
   logic [7:0] rd_val;
   assign rd_val = hit_cc   ? cc_q :
                   hit_prio ? prio_rd[poff[1:0]] :
                   hit_s0   ? sens0_q :
                   hit_s1   ? {6'h00, sens1_q} :
                   hit_en   ? en_q[{eoff[2:0], 3'h0} +: 8] :
                   hit_fl   ? flag_q[{foff[2:0], 3'h0} +: 8] :
                   eipc_pkg::REG_ZERO;

   //------------------------------------------------------------
   // Priority field writes
   //------------------------------------------------------------
   logic [3:0] wr_prio;
   genvar r;
   genvar f;
   generate
      for (r = 0; r < 4; r++)
      begin : g_prio
         assign wr_prio[r] = wr & hit_prio & (poff[1:0] == 2'(r));
         for (f = 0; f < 4; f++)
         begin : g_fld
            // Level 0 code is refused per field, old value kept
            assign prio_d[r][2*f +: 2] =
               (!wr_prio[r] || (r == 3 && f >= 2)) ? prio_q[r][2*f +: 2] :
               (wdat[2*f +: 2] == eipc_pkg::PRIO_L0) ? prio_q[r][2*f +: 2] :
               wdat[2*f +: 2];
         end
      end
   endgenerate

   //------------------------------------------------------------
   // Sensitivity writes and group clear on change
   //------------------------------------------------------------
   logic [4:0][1:0] sens_cur;
   logic [4:0][1:0] sens_new;
   logic [4:0]      sens_chg;
   logic            wr_s0;
   logic            wr_s1;

   // Writes only land at level 3
   assign wr_s0   = wr & hit_s0 & at_l3;
   assign wr_s1   = wr & hit_s1 & at_l3;
   assign sens0_d = wr_s0 ? wdat : sens0_q;
   assign sens1_d = wr_s1 ? wdat[1:0] : sens1_q;
   assign sens_cur = {sens1_q, sens0_q};
   assign sens_new = {sens1_d, sens0_d};

   // A changed field drops that group's pending flags
   generate
      for (r = 0; r < eipc_pkg::NUM_GRP; r++)
      begin : g_chg
         assign sens_chg[r] = (sens_new[r] != sens_cur[r]);
      end
   endgenerate

   //------------------------------------------------------------
   // Enable and flag next values
   //------------------------------------------------------------
   logic [39:0] ev_set;
   logic [39:0] sw_clr;
   logic [4:0]  irq_d;
   generate
      for (r = 0; r < eipc_pkg::NUM_GRP; r++)
      begin : g_grp
         logic wr_e;
         logic wr_f;
         assign wr_e = wr & hit_en & (eoff[2:0] == 3'(r));
         assign wr_f = wr & hit_fl & (foff[2:0] == 3'(r));
         assign en_d[8*r +: 8] = wr_e ? wdat : en_q[8*r +: 8];
         // Writing 0 clears, writing 1 leaves the flag alone
         assign sw_clr[8*r +: 8] = (wr_f ? ~wdat : 8'h00) |
                                   (sens_chg[r] ? 8'hFF : 8'h00);
         assign irq_d[r] = |(flag_q[8*r +: 8] & en_q[8*r +: 8]);
      end
   endgenerate

   // Hardware set has priority over any clear
   assign flag_d = ev_set | (flag_q & ~sw_clr);

   //------------------------------------------------------------
   // Pin event detection
   //------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < 40; p++)
      begin : g_pin
         logic [1:0] mode;
         logic       rise;
         logic       fall;
         assign mode = sens_cur[p / 8];
         assign rise = sync2_q[p] & ~prev_q[p];
         assign fall = ~sync2_q[p] & prev_q[p];
         // Low level keeps setting in fall-and-low mode
         assign ev_set[p] =
            (mode == eipc_pkg::SENS_FALL_LOW) ? ~sync2_q[p] :
            (mode == eipc_pkg::SENS_RISE)     ? rise :
            (mode == eipc_pkg::SENS_FALL)     ? fall :
            (rise | fall);
      end
   endgenerate

   //------------------------------------------------------------
   // Condition code next value
   //------------------------------------------------------------
   logic [1:0] ent_code;
   logic [4:0] ent_pos;
   // Vectors 14 and 15 have no field and read as level 3
   assign ent_pos  = {cpu_evt_i.vec, 1'b0};
   assign ent_code = prio_flat[ent_pos +: 2];

   // Trap/reset, then entry, then core load, then bus write
   always_comb
   begin
      cc_d = cc_q;
      if (cpu_evt_i.nmi)
      begin
         cc_d[eipc_pkg::CC_HI_BIT] = 1'b1;
         cc_d[eipc_pkg::CC_LO_BIT] = 1'b1;
      end
      else if (cpu_evt_i.enter)
      begin
         cc_d[eipc_pkg::CC_HI_BIT] = ent_code[1];
         cc_d[eipc_pkg::CC_LO_BIT] = ent_code[0];
      end
      else if (cpu_evt_i.cc_load)
      begin
         cc_d = cpu_evt_i.cc_val;
      end
      else if (wr & hit_cc)
      begin
         cc_d = wdat;
      end
   end

   //------------------------------------------------------------
   // Re-entry of the running vector on a raised priority
   //------------------------------------------------------------
   logic [13:0] pend_all;
   logic [4:0]  run_pos;
   logic [1:0]  run_new;
   logic [1:0]  cur_lvl;
   logic [31:0] prio_d_flat;

   // External groups contribute their own request levels
   assign pend_all    = vec_pend_i | {5'h00, irq_q, 4'h0};
   assign prio_d_flat = {4'hF, prio_d[3][3:0], prio_d[2], prio_d[1], prio_d[0]};
   assign run_pos     = {run_vec_q, 1'b0};
   assign run_new     = prio_d_flat[run_pos +: 2];
   assign cur_lvl     = code_level({cc_q[eipc_pkg::CC_HI_BIT], cc_q[eipc_pkg::CC_LO_BIT]});
   assign reenter_d   = run_q & (|wr_prio) & !cpu_evt_i.enter &
                        (run_vec_q < 4'hE) & pend_all[run_vec_q] &
                        (code_level(run_new) > cur_lvl);

   //------------------------------------------------------------
   // Pin synchroniser
   //------------------------------------------------------------
   // Two stages before any edge logic
   // Stages reset to the idle high level so release shows no false event
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         sync1_q <= 40'hFF_FFFF_FFFF;
         sync2_q <= 40'hFF_FFFF_FFFF;
         prev_q  <= 40'hFF_FFFF_FFFF;
      end
      else
      begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   //------------------------------------------------------------
   // Register file
   //------------------------------------------------------------
   // Configuration and status registers
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cc_q    <= eipc_pkg::CC_RESET;
         prio_q  <= {4{eipc_pkg::PRIO_RESET}};
         sens0_q <= eipc_pkg::REG_ZERO;
         sens1_q <= 2'h0;
         en_q    <= 40'h00_0000_0000;
         flag_q  <= 40'h00_0000_0000;
         irq_q   <= 5'h00;
      end
      else
      begin
         cc_q    <= cc_d;
         prio_q  <= prio_d;
         sens0_q <= sens0_d;
         sens1_q <= sens1_d;
         en_q    <= en_d;
         flag_q  <= flag_d;
         irq_q   <= irq_d;
      end
   end

   // Running vector tracking for re-entry
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         run_q     <= 1'b0;
         run_vec_q <= 4'h0;
         reenter_q <= 1'b0;
      end
      else
      begin
         reenter_q <= reenter_d;
         if (cpu_evt_i.enter)
         begin
            run_q     <= 1'b1;
            run_vec_q <= cpu_evt_i.vec;
         end
         else if (cpu_evt_i.ret | cpu_evt_i.nmi)
         begin
            run_q <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------
   // Wishbone answer
   //------------------------------------------------------------
   // Ack one cycle after the request, dropped the cycle after
   // A write lands on the edge at which the master sees ack high
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= eipc_pkg::REG_ZERO;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q)
         begin
            dat_q <= rd_val;
         end
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign ack_o     = ack_q;
   assign dat_o     = {24'h00_0000, dat_q};
   assign cc_o      = cc_q;
   assign grp_irq_o = irq_q;
   assign reenter_o = reenter_q;

endmodule // eipc_top

/* hw/eipc_irq_d_fix.sv */
// Spare design file without logic; the whole block lives in eipc_top


/* testbench/eipc_chk.sv */
// Port-level concurrent checks for the interrupt priority controller
module eipc_chk (
   input wire logic                    clock_i,
   input wire logic                    rst_i,
   input wire logic                    cyc_i,
   input wire logic                    stb_i,
   input wire logic                    we_i,
   input wire logic [9:0]              adr_i,
   input wire logic [31:0]             dat_i,
   input wire logic [3:0]              sel_i,
   input wire logic                    ack_o,
   input wire logic [31:0]             dat_o,
   input wire eipc_pkg::eipc_cpu_evt_s cpu_evt_i,
   input wire logic [13:0]             vec_pend_i,
   input wire logic [39:0]             pin_i,
   input wire logic [7:0]              cc_o,
   input wire logic [27:0]             vec_prio_o,
   input wire logic [4:0]              grp_irq_o,
   input wire logic                    reenter_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff rst_i;
   // ---------------------------------------------
   // Helper logic
   // ---------------------------------------------
   logic [1:0] ent_fld;
   logic       wr_ack;
   logic       lvl0_seen;
   // Field of the entered vector and completed bus writes
   assign ent_fld = vec_prio_o[{cpu_evt_i.vec, 1'h0} +: 2];
   assign wr_ack  = cyc_i & stb_i & we_i & ack_o;
   // Any priority field holding the level 0 code
   always_comb
   begin
      lvl0_seen = 1'h0;
      for (int v = 0; v < eipc_pkg::NUM_VEC; v++)
         lvl0_seen |= (vec_prio_o[2*v +: 2] == eipc_pkg::PRIO_L0);
   end
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   chk_cc_reset: assert property ($fell(rst_i) |-> cc_o == eipc_pkg::CC_RESET)
      else $error("cc_o not at reset value");
   chk_prio_reset: assert property ($fell(rst_i) |-> &vec_prio_o && grp_irq_o == 5'h00)
      else $error("priority or group request not at reset value");
   chk_nmi_sets: assert property (cpu_evt_i.nmi |=> cc_o[5] && cc_o[3])
      else $error("trap service did not set both level bits");
   chk_enter_load: assert property (cpu_evt_i.enter && !cpu_evt_i.nmi
      |=> {cc_o[5], cc_o[3]} == $past(ent_fld))
      else $error("entry did not load the vector field");
   chk_cc_load: assert property (cpu_evt_i.cc_load && !cpu_evt_i.enter && !cpu_evt_i.nmi
      |=> cc_o == $past(cpu_evt_i.cc_val))
      else $error("instruction load of cc_o lost");
   chk_cc_hold: assert property (!cpu_evt_i.cc_load && !cpu_evt_i.enter && !cpu_evt_i.nmi
      && !wr_ack |=> $stable(cc_o))
      else $error("cc_o changed without cause");
   chk_no_level0: assert property (!lvl0_seen)
      else $error("a priority field holds the level 0 code");
   chk_ack_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack_o not a one cycle answer");
   chk_reenter_src: assert property (reenter_o |-> $past(wr_ack) || $past(wr_ack, 2))
      else $error("reenter_o without a priority write");
   chk_reenter_once: assert property (reenter_o |=> !reenter_o)
      else $error("reenter_o longer than one cycle");
   // Main scenarios reached
   cover property (cpu_evt_i.enter);
   cover property (cpu_evt_i.nmi);
   cover property (reenter_o);
   cover property ($rose(grp_irq_o[0]));
endmodule // eipc_chk

bind eipc_top eipc_chk u_chk (
   .clock_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .ack_o, .dat_o,
   .cpu_evt_i, .vec_pend_i, .pin_i, .cc_o, .vec_prio_o, .grp_irq_o, .reenter_o
);

/* testbench/eipc_cpu_mdl.sv */
// Model of the CPU core events and the port pins
module eipc_cpu_mdl (
   input  wire logic                    clock_i,
   output      eipc_pkg::eipc_cpu_evt_s cpu_evt_o,
   output      logic [13:0]             vec_pend_o,
   output      logic [39:0]             pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle core, pins pulled high
   initial
   begin
      cpu_evt_o  = '0;
      vec_pend_o = 14'h0000;
      pin_o      = {40{1'h1}};
   end
   // One cycle event pulse from the core
   task automatic pulse(input eipc_pkg::eipc_cpu_evt_s e);
      @(posedge clock_i);
      cpu_evt_o <= e;
      @(posedge clock_i);
      cpu_evt_o <= '0;
   endtask
   // Pin levels, held for five cycles so the synchroniser sees them
   task automatic pins(input logic [39:0] p);
      @(posedge clock_i);
      pin_o <= p;
      repeat (5) @(posedge clock_i);
   endtask
   // Pending levels of all 14 vectors, the external group positions included
   task automatic pend(input logic [13:0] p);
      @(posedge clock_i);
      vec_pend_o <= p;
   endtask
endmodule // eipc_cpu_mdl

/* testbench/eipc_top_tb.sv */
// Self-checking bench for the interrupt priority controller
module eipc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    clock_i    = 1'h0;
   logic                    rst_i      = 1'h1;
   logic                    cyc        = 1'h0;
   logic                    stb        = 1'h0;
   logic                    we         = 1'h0;
   logic [9:0]              adr        = 10'h000;
   logic [31:0]             dat        = 32'h0;
   logic [3:0]              sel        = 4'h0;
   logic                    ack;
   logic [31:0]             rdat;
   eipc_pkg::eipc_cpu_evt_s evt;
   logic [13:0]             pend;
   logic [39:0]             pin;
   logic [7:0]              cc;
   logic [27:0]             vprio;
   logic [4:0]              girq;
   logic                    reent;
   int                      mismatches = 0;
   int                      num_checks = 0;
   int                      reent_cnt  = 0;
   // ---------------------------------------------
   // Clock, design and far side
   // ---------------------------------------------
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) if (reent === 1'h1) reent_cnt++;
   eipc_top dut (
      .clock_i(clock_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(dat), .sel_i(sel), .ack_o(ack), .dat_o(rdat),
      .cpu_evt_i(evt), .vec_pend_i(pend), .pin_i(pin), .cc_o(cc),
      .vec_prio_o(vprio), .grp_irq_o(girq), .reenter_o(reent)
   );
   eipc_cpu_mdl mdl (.clock_i(clock_i), .cpu_evt_o(evt), .vec_pend_o(pend), .pin_o(pin));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Wishbone classic single access, held until ack
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
      @(posedge clock_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we  <= w;
      adr <= {idx, 2'h0};
      dat <= {24'h0, d};
      sel <= 4'h1;
      @(posedge clock_i);
      while (ack !== 1'h1)
         @(posedge clock_i);
      q = rdat[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we  <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'h1, idx, d, q);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'h0, idx, 8'h00, q);
      check(nm, {24'h0, q}, {24'h0, exp});
   endtask
   // Core event: entry, vector, trap, return, cc load, cc value
   task automatic ev(input logic en, input logic [3:0] v, input logic n, input logic r,
                     input logic l, input logic [7:0] c);
      mdl.pulse({en, v, n, r, l, c});
      @(negedge clock_i);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      rdc("cc", eipc_pkg::IDX_CC, eipc_pkg::CC_RESET);
      for (int i = 0; i < 16; i++)
         rdc("regmap", eipc_pkg::IDX_PRIO0 + 8'(i), (i < 4) ? 8'hFF : 8'h00);
      wr(8'h50, 8'hAA);
      rdc("unmapped", 8'h50, 8'h00);
      check("prio_o", {4'h0, vprio}, 32'h0FFFFFFF);
   endtask
   task automatic t_prio;
      wr(eipc_pkg::IDX_PRIO0, 8'hCF);
      wr(eipc_pkg::IDX_PRIO0, 8'h64);
      rdc("prio0", eipc_pkg::IDX_PRIO0, 8'h44);
      check("prio_o", {24'h0, vprio[7:0]}, 32'h44);
      wr(eipc_pkg::IDX_PRIO3, 8'h00);
      rdc("prio3", eipc_pkg::IDX_PRIO3, 8'hF0);
   endtask
   task automatic t_enter;
      ev(1'h1, 4'h1, 1'h0, 1'h0, 1'h0, 8'h00);
      check("enter", {cc[5], cc[3]}, 32'h1);
      ev(1'h0, 4'h0, 1'h1, 1'h0, 1'h0, 8'h00);
      check("trap", {cc[5], cc[3]}, 32'h3);
      ev(1'h0, 4'h0, 1'h0, 1'h0, 1'h1, 8'h28);
      rdc("cc_load", eipc_pkg::IDX_CC, 8'h28);
   endtask
   task automatic t_sense;
      ev(1'h0, 4'h0, 1'h0, 1'h0, 1'h1, 8'hE2);
      wr(eipc_pkg::IDX_SENS0, 8'h55);
      rdc("sense_lock", eipc_pkg::IDX_SENS0, 8'h00);
      wr(eipc_pkg::IDX_CC, 8'hEA);
      wr(eipc_pkg::IDX_SENS0, 8'hE4);
      rdc("sense0", eipc_pkg::IDX_SENS0, 8'hE4);
      wr(eipc_pkg::IDX_SENS1, 8'hFF);
      rdc("sense1", eipc_pkg::IDX_SENS1, 8'h03);
      wr(eipc_pkg::IDX_SENS0, 8'h00);
   endtask
   // Port A pin 0 through all four sense modes
   task automatic t_modes;
      logic [3:0] rise_set;
      logic [3:0] fall_set;
      rise_set = 4'hA;
      fall_set = 4'hD;
      wr(eipc_pkg::IDX_EN_A, 8'h01);
      for (int m = 0; m < 4; m++)
      begin
         wr(eipc_pkg::IDX_SENS0, 8'(m));
         rdc("sense_clr", eipc_pkg::IDX_FL_A, 8'h00);
         mdl.pins({{39{1'h1}}, 1'h0});
         rdc("fall", eipc_pkg::IDX_FL_A, {7'h0, fall_set[m]});
         check("grp_irq", {31'h0, girq[0]}, {31'h0, fall_set[m]});
         wr(eipc_pkg::IDX_FL_A, 8'h00);
         rdc("low_level", eipc_pkg::IDX_FL_A, {7'h0, m == 0});
         mdl.pins({40{1'h1}});
         rdc("rise", eipc_pkg::IDX_FL_A, {7'h0, rise_set[m] | (m == 0)});
      end
      wr(eipc_pkg::IDX_SENS0, 8'h00);
      rdc("sense_clr", eipc_pkg::IDX_FL_A, 8'h00);
   endtask
   // Raising a running, pending vector's field re-enters it once
   task automatic t_reenter;
      wr(eipc_pkg::IDX_PRIO0 + 8'h01, 8'hFD);
      ev(1'h1, 4'h4, 1'h0, 1'h0, 1'h0, 8'h00);
      mdl.pend(14'h0010);
      wr(eipc_pkg::IDX_PRIO0 + 8'h01, 8'hFF);
      wr(eipc_pkg::IDX_PRIO0 + 8'h01, 8'hFD);
      mdl.pend(14'h0000);
      wr(eipc_pkg::IDX_PRIO0 + 8'h01, 8'hFF);
      ev(1'h0, 4'h0, 1'h0, 1'h1, 1'h1, 8'hEA);
      check("reenter", reent_cnt, 32'h1);
   endtask
   // ---------------------------------------------
   // Sequence, watchdog and verdict
   // ---------------------------------------------
   task automatic close_out;
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'h0;
      t_reset;
      t_prio;
      t_enter;
      t_sense;
      t_modes;
      t_reenter;
      close_out;
   end
   initial
   begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      close_out;
   end
endmodule // eipc_top_tb
